// [dv/ccd_ctrl_model.sv]
`timescale 1ns/1ps
module ccd_ctrl_model (
   output logic link_clk,
   output ccd_pkg::ccd_sym_t link_sym
);
   import ccd_pkg::*;
   initial begin
      link_clk = 1'b0;
      link_sym = '0;
   end
   // Clock stands low between symbols; released lines flip so stale values never pass
   task automatic sym(input logic [1:0] k, input logic [7:0] d);
      link_sym <= '{1'b1, k, d};
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      link_sym <= '{1'b0, ~k, ~d};
   endtask
endmodule

// [dv/ccd_decoder_bench.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module ccd_decoder_bench;
   import ccd_pkg::*;
   logic clock, nrst, link_clk, dv, ip, mp, hp, ack, rl, dj, fb, stb;
   ccd_sym_t link_sym;
   logic [15:0] status_word, wl, rdl;
   logic [6:0] da;
   logic [1:0] act;
   logic [7:0] pl, rd;
   ccd_cmd_info_t info;
   int fails = 0;
   int checks = 0;
   ccd_ctrl_model ctl (.link_clk(link_clk), .link_sym(link_sym));
   ccd_decoder dut (.clock(clock), .nrst(nrst), .link_clk(link_clk), .link_sym(link_sym),
      .status_word(status_word), .dyn_addr(da), .dyn_addr_valid(dv), .act_state(act),
      .interrupt_request_permit(ip), .mastership_request_permit(mp), .hot_join_permit(hp),
      .write_limit(wl), .read_limit(rdl), .payload_limit(pl), .addr_ack(ack),
      .resp_data(rd), .resp_last(rl), .daa_join(dj), .fast_mode_busy(fb), .cmd_stb(stb),
      .cmd_info(info));
   task automatic cmd(input logic [7:0] c);
      ctl.sym(K_ADDR, 8'hFC);
      ctl.sym(K_DATA, c);
   endtask
   task automatic fin;
      ctl.sym(K_STOP, 8'h00);
      @(posedge clock);
      $display("test done at %0t", $time);
   endtask
   task automatic t_events;
      cmd(8'h01);
      ctl.sym(K_DATA, 8'h0B);
      `CHK("permits", 3'h0, {ip, mp, hp})
      fin;
      cmd(8'h00);
      ctl.sym(K_DATA, 8'h01);
      `CHK("permits", 3'h4, {ip, mp, hp})
      `CHK("info", {8'h00, 1'b0, CL_REQUIRED}, info)
      fin;
   endtask
   task automatic t_addr;
      cmd(8'h29);
      `CHK("static", 8'hBA, {dv, da})
      fin;
      cmd(8'h88);
      ctl.sym(K_ADDR, 8'h74);
      `CHK("ack", 1'b1, ack)
      ctl.sym(K_DATA, 8'hA4);
      fin;
      `CHK("new", 7'h52, da)
      cmd(8'h07);
      `CHK("join", 1'b0, dj)
      fin;
   endtask
   task automatic t_act;
      cmd(8'h03);
      `CHK("act", 2'h1, act)
      fin;
      cmd(8'h02);
      `CHK("act", 2'h0, act)
      fin;
      cmd(8'h04);
      `CHK("act", 2'h2, act)
      fin;
      cmd(8'h82);
      ctl.sym(K_ADDR, 8'hA4);
      fin;
      `CHK("act", 2'h0, act)
      cmd(8'h8E);
      ctl.sym(K_ADDR, 8'hA5);
      `CHK("get", 10'h301, {ack, rl, rd})
      ctl.sym(K_DATA, 8'h00);
      fin;
   endtask
   task automatic t_refuse;
      cmd(8'h92);
      ctl.sym(K_ADDR, 8'hA4);
      `CHK("ack", 1'b0, ack)
      `CHK("cls", CL_RESERVED, info.cls)
      fin;
      cmd(8'h61);
      `CHK("cls", CL_VENDOR, info.cls)
      fin;
      `CHK("kept", 10'h0D2, {act, dv, da})
   endtask
   task automatic t_limits;
      cmd(8'h89);
      ctl.sym(K_ADDR, 8'hA4);
      ctl.sym(K_DATA, 8'h00);
      ctl.sym(K_DATA, 8'h04);
      fin;
      `CHK("wl", 16'h0040, wl)
      cmd(8'h09);
      ctl.sym(K_DATA, 8'h00);
      ctl.sym(K_DATA, 8'h20);
      fin;
      `CHK("wl", 16'h0020, wl)
      cmd(8'h0A);
      ctl.sym(K_DATA, 8'h00);
      ctl.sym(K_DATA, 8'h10);
      ctl.sym(K_DATA, 8'h05);
      fin;
      `CHK("rl", 16'h0010, rdl)
      `CHK("pl", 8'h00, pl)
   endtask
   task automatic t_fast;
      cmd(8'h20);
      ctl.sym(K_STOP, 8'h00);
      `CHK("fast", 1'b1, fb)
      ctl.sym(K_FAST_EXIT, 8'h00);
      `CHK("fast", 1'b0, fb)
      cmd(8'h06);
      fin;
      `CHK("dv", 1'b0, dv)
      cmd(8'h07);
      `CHK("join", 1'b1, dj)
      fin;
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Whole run is about 70 link symbols, well inside this span
   initial begin
      #100000;
      fails++;
      stop_test;
   end
   initial begin
      nrst = 1'b0;
      status_word = 16'h0000;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK("reset", 7'h1C, {act, ip, mp, hp, dv, stb})
      t_events;
      t_addr;
      t_act;
      t_refuse;
      t_limits;
      t_fast;
      stop_test;
   end
endmodule

// [src/ccd_decoder.sv]
//
// Overview of operation
// R01: Code bit 7 low means broadcast, high means direct.
// R02: A command frame opens with broadcast address 7E and write bit.
// R03: Enable-events codes 00/80 set the interrupt, mastership and hot-join permits.
// R04: Disable-events codes 01/81 clear the selected permits.
// R05: Activity state zero codes 02/82 select normal operation, the default.
// R06: Optional activity states one to three via codes 03-05 and 83-85.
// R07: Device may self-manage power from the last announced activity state.
// R08: Reset-address codes 06/86 drop the dynamic address; support mandatory.
// R09: Assignment-enter 07 joins only when no dynamic address is held.
// R10: Optional target list broadcast 08 announces addresses and traits.
// R11: Decode write limit set 09/89 and get 8B.
// R12: Decode read limit set 0A/8A and get 8C.
// R13: Devices moving 16 or more bytes implement direct limit set and get.
// R14: Fast mode entries 20-27 unsupported; still track entry, restart and exit.
// R15: Broadcast 29 makes a known static address the dynamic address.
// R16: Optional direct 87 gives a dynamic address via static address.
// R17: Direct 88 replaces the dynamic address with the sent value.
// R18: Answer 8D identifier, 8E bus traits, 8F device traits, 90 status.
// R19: Optional 91 mastership handover for secondary controller capable devices.
// R20: Optional 93 lists bridge endpoints.
// R21: With bus traits bit 0 set, answer 94 with speed limits.
// R22: 95 needed only with fast modes; timing exchange codes excluded.
// R23: Listed reserved ranges are not implemented commands.
// R24: Codes 61-7F and E0-FE are vendor extensions.
// R25: Reserved, unsupported or unimplemented codes leave state alone until frame end.
// R26: Reset gives activity state zero and default event permits.
//
// Our own choices: the strobed register port.
`timescale 1ns/1ps
module ccd_decoder #(
   parameter logic [6:0] STATIC_ADDR = 7'h3A,
   parameter logic STATIC_KNOWN = 1'b1,
   parameter logic HAS_LOW_ACTIVITY = 1'b1,
   parameter logic [47:0] PROV_ID = 48'h0000_0000_0001, // Arbitrary value
   parameter logic [7:0] BUS_TRAITS = 8'h01,
   parameter logic [7:0] DEVICE_TRAITS = 8'h00,
   parameter logic [7:0] MAX_WR_SPEED = 8'h00,
   parameter logic [7:0] MAX_RD_SPEED = 8'h00
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic link_clk,
   input wire ccd_pkg::ccd_sym_t link_sym,
   input wire logic [15:0] status_word,
   output logic [6:0] dyn_addr,
   output logic dyn_addr_valid,
   output logic [1:0] act_state,
   output logic interrupt_request_permit,
   output logic mastership_request_permit,
   output logic hot_join_permit,
   output logic [15:0] write_limit,
   output logic [15:0] read_limit,
   output logic [7:0] payload_limit,
   output logic addr_ack,
   output logic [7:0] resp_data,
   output logic resp_last,
   output logic daa_join,
   output logic fast_mode_busy,
   output logic cmd_stb,
   output ccd_pkg::ccd_cmd_info_t cmd_info
);
   import ccd_pkg::*;

   function automatic ccd_class_t classify(input logic [7:0] c);
      if ((c >= VENDOR_B_FIRST && c <= 8'h7F) || (c >= VENDOR_D_FIRST && c <= VENDOR_D_LAST))
         return CL_VENDOR; // see R24
      if ((c >= RESERVED_B_FIRST && c <= RESERVED_B_LAST) || c == RESERVED_D_SINGLE ||
          (c >= RESERVED_B2_FIRST && c <= RESERVED_B2_LAST) || c == 8'hFF ||
          (c >= RESERVED_D_FIRST && c <= RESERVED_D_LAST) ||
          (c >= RESERVED_D2_FIRST && c <= RESERVED_D2_LAST))
         return CL_RESERVED; // see R23
      if ((c >= FAST_MODE_ZERO_ENTRY_CMD && c <= TIMING_EXCHANGE_CMD_B) ||
          c == TEST_MODE_CMD || c == FAST_MODE_CAPS_GET_CMD ||
          c == TIMING_EXCHANGE_SET_CMD || c == TIMING_EXCHANGE_GET_CMD)
         return CL_UNSUPPORTED; // see R14 see R22
      if ((c > ACTIVITY_STATE_ZERO_CMD_B && c <= ACTIVITY_STATE_THREE_CMD_B) ||
          (c > ACTIVITY_STATE_ZERO_CMD_D && c <= ACTIVITY_STATE_THREE_CMD_D) ||
          c == TARGET_LIST_DEFINE_CMD || c == DYN_FROM_STATIC_ASSIGN_CMD ||
          c == MASTERSHIP_ACCEPT_GET_CMD || c == BRIDGE_ENDPOINTS_SET_CMD ||
          c == SPEED_LIMITS_GET_CMD)
         return CL_OPTIONAL; // see R06 see R10 see R16 see R19 see R20
      return CL_REQUIRED;
   endfunction

   // Whether this block acts on a code; list, handover and bridge codes go to the user
   function automatic logic acted(input logic [7:0] c);
      ccd_class_t k;
      k = classify(c);
      if (k == CL_REQUIRED)
         return 1'b1;
      if (k != CL_OPTIONAL)
         return 1'b0; // see R25
      if ((c & 8'h7F) > ACTIVITY_STATE_ZERO_CMD_B && (c & 8'h7F) <= ACTIVITY_STATE_THREE_CMD_B)
         return HAS_LOW_ACTIVITY; // see R06
      if (c == DYN_FROM_STATIC_ASSIGN_CMD)
         return STATIC_KNOWN; // see R16
      if (c == SPEED_LIMITS_GET_CMD)
         return BUS_TRAITS[TRAITS_SPEED_BIT]; // see R21
      return 1'b0;
   endfunction

   function automatic logic is_get(input logic [7:0] c);
      return (c >= WRITE_LIMIT_GET_CMD && c <= MASTERSHIP_ACCEPT_GET_CMD) ||
             c == SPEED_LIMITS_GET_CMD || c == FAST_MODE_CAPS_GET_CMD ||
             c == TIMING_EXCHANGE_GET_CMD;
   endfunction

   function automatic logic is_as(input logic [7:0] c);
      return (c >= ACTIVITY_STATE_ZERO_CMD_B && c <= ACTIVITY_STATE_THREE_CMD_B) ||
             (c >= ACTIVITY_STATE_ZERO_CMD_D && c <= ACTIVITY_STATE_THREE_CMD_D);
   endfunction

   // Two-flop synchronisers; the link clock is sampled, not used as a clock
   logic scl_s1_r, scl_s2_r, scl_d_r;
   ccd_sym_t sym_s1_r, sym_s2_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         scl_s1_r <= 1'b0;
         scl_s2_r <= 1'b0;
         scl_d_r <= 1'b0;
         sym_s1_r <= '0;
         sym_s2_r <= '0;
      end else begin
         scl_s1_r <= link_clk;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sym_s1_r <= link_sym;
         sym_s2_r <= sym_s1_r;
      end
   end

   ccd_state_t st_r, st_nxt, route;
   logic [7:0] cmd_r, tmp_r;
   logic [2:0] idx_r;
   logic [6:0] dyn_addr_r;
   logic dyn_valid_r;
   logic [1:0] act_r;
   logic int_ok_r, mr_ok_r, hj_ok_r;
   logic [15:0] wr_lim_r, rd_lim_r;
   logic [7:0] pay_lim_r;
   logic ack_r, last_r, stb_r;
   logic [7:0] resp_r;
   ccd_cmd_info_t info_r;

   // Symbol decode at each sampled rising link clock edge
   wire take = scl_s2_r & ~scl_d_r & sym_s2_r.valid;
   wire [7:0] code = sym_s2_r.data;
   wire is_addr = take && sym_s2_r.kind == K_ADDR;
   wire is_data = take && sym_s2_r.kind == K_DATA;
   wire is_stop = take && sym_s2_r.kind == K_STOP;
   wire is_fexit = take && sym_s2_r.kind == K_FAST_EXIT;
   wire bc_addr_w = code == {BCAST_ADDR, 1'b0}; // see R02
   wire rnw = code[0];
   wire own_dyn = dyn_valid_r && code[7:1] == dyn_addr_r;
   wire own_static = cmd_r == DYN_FROM_STATIC_ASSIGN_CMD && !dyn_valid_r && STATIC_KNOWN &&
                     code[7:1] == STATIC_ADDR;
   wire dir_ok = acted(cmd_r) && rnw == is_get(cmd_r);
   wire own_hit = (own_dyn || own_static) && dir_ok;
   wire in_dir = st_r == ST_DWAIT || st_r == ST_DWR || st_r == ST_DRD;
   wire cmd_take = st_r == ST_CMD && is_data;
   wire bc_now = cmd_take && !code[7] && acted(code); // see R01
   wire own_wr = in_dir && is_addr && !bc_addr_w && own_hit && !rnw;
   wire own_rd = in_dir && is_addr && !bc_addr_w && own_hit && rnw;
   wire wr_data = is_data && (st_r == ST_BDATA || st_r == ST_DWR);
   wire ev_en = wr_data && idx_r == 3'h0 &&
                (cmd_r == ENABLE_EVENTS_CMD_B || cmd_r == ENABLE_EVENTS_CMD_D);
   wire ev_dis = wr_data && idx_r == 3'h0 &&
                 (cmd_r == DISABLE_EVENTS_CMD_B || cmd_r == DISABLE_EVENTS_CMD_D);
   wire as_b = bc_now && is_as(code);
   wire as_d = own_wr && is_as(cmd_r);
   wire [1:0] as_val = as_b ? 2'(code[2:0] - 3'h2) : 2'(cmd_r[2:0] - 3'h2);
   wire addr_drop = (bc_now && code == DYN_ADDR_RESET_CMD_B) ||
                    (own_wr && cmd_r == DYN_ADDR_RESET_CMD_D);
   wire aasa = bc_now && code == STATIC_AS_DYNAMIC_CMD && STATIC_KNOWN;
   wire newda = wr_data && st_r == ST_DWR && idx_r == 3'h0 &&
                (cmd_r == DYN_ADDR_REPLACE_CMD || cmd_r == DYN_FROM_STATIC_ASSIGN_CMD);
   wire mwl_set = wr_data && idx_r == 3'h1 &&
                  (cmd_r == WRITE_LIMIT_SET_CMD_B || cmd_r == WRITE_LIMIT_SET_CMD_D);
   wire is_mrl = cmd_r == READ_LIMIT_SET_CMD_B || cmd_r == READ_LIMIT_SET_CMD_D;
   wire mrl_set = wr_data && idx_r == 3'h1 && is_mrl;
   wire pay_set = wr_data && idx_r == 3'h2 && is_mrl;
   wire [15:0] lim_in = {tmp_r, code};

   // Route after a command code
   always_comb begin
      if (code >= FAST_MODE_ZERO_ENTRY_CMD && code <= FAST_MODE_LAST_ENTRY_CMD)
         route = ST_FAST; // see R14
      else if (!acted(code))
         route = ST_SKIP; // see R25
      else if (code == DYN_ADDR_ASSIGN_ENTER_CMD)
         route = dyn_valid_r ? ST_SKIP : ST_DAA; // see R09
      else if (code[7])
         route = ST_DWAIT;
      else
         route = ST_BDATA;
   end

   always_comb begin
      st_nxt = st_r;
      if (is_stop && st_r != ST_FAST) begin
         st_nxt = ST_IDLE;
      end else begin
         case (st_r)
            ST_IDLE, ST_BDATA: begin
               if (is_addr)
                  st_nxt = bc_addr_w ? ST_CMD : ST_IDLE; // see R02
            end
            ST_CMD: begin
               if (is_data)
                  st_nxt = route;
               else if (is_addr)
                  st_nxt = bc_addr_w ? ST_CMD : ST_IDLE;
            end
            ST_DWAIT, ST_DWR, ST_DRD: begin
               if (is_addr) begin
                  if (bc_addr_w)
                     st_nxt = ST_CMD;
                  else if (own_hit)
                     st_nxt = rnw ? ST_DRD : ST_DWR;
                  else
                     st_nxt = ST_DWAIT;
               end
            end
            ST_SKIP: begin
               if (is_addr && bc_addr_w)
                  st_nxt = ST_CMD;
               else if (is_addr && !cmd_r[7])
                  st_nxt = ST_IDLE; // see R25
            end
            ST_DAA: st_nxt = ST_DAA;
            ST_FAST: begin
               if (is_fexit)
                  st_nxt = ST_IDLE; // see R14
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   // Read answers, most significant byte first
   logic [47:0] resp_word;
   logic [2:0] resp_len;
   wire [2:0] rd_idx = own_rd ? 3'h0 : 3'(idx_r + 3'h1);
   always_comb begin
      resp_word = '0;
      resp_len = 3'h1;
      case (cmd_r)
         WRITE_LIMIT_GET_CMD: begin
            resp_word = {wr_lim_r, 32'h0000_0000}; // see R11 see R13
            resp_len = 3'h2;
         end
         READ_LIMIT_GET_CMD: begin
            resp_word = {rd_lim_r, pay_lim_r, 24'h00_0000}; // see R12 see R13
            resp_len = BUS_TRAITS[TRAITS_PAYLOAD_BIT] ? 3'h3 : 3'h2;
         end
         PROVISIONAL_ID_GET_CMD: begin
            resp_word = PROV_ID; // see R18
            resp_len = 3'h6;
         end
         BUS_TRAITS_GET_CMD: resp_word = {BUS_TRAITS, 40'h00_0000_0000}; // see R18
         DEVICE_TRAITS_GET_CMD: resp_word = {DEVICE_TRAITS, 40'h00_0000_0000}; // see R18
         OPERATING_STATE_GET_CMD: begin
            resp_word = {status_word, 32'h0000_0000}; // see R18
            resp_len = 3'h2;
         end
         SPEED_LIMITS_GET_CMD: begin
            resp_word = {MAX_WR_SPEED, MAX_RD_SPEED, 32'h0000_0000}; // see R21
            resp_len = 3'h2;
         end
         default: resp_len = 3'h1;
      endcase
   end
   // Bytes past the answer read as zero up to the eighth; from the ninth on the first byte repeats; the controller ignores extras
   wire [7:0] resp_byte = rd_idx < resp_len ? resp_word[47 - 8 * rd_idx -: 8] : 8'h00;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_r <= ST_IDLE;
         cmd_r <= 8'hFF;
         idx_r <= 3'h0;
         tmp_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         if (cmd_take)
            cmd_r <= code;
         if (cmd_take || is_addr)
            idx_r <= 3'h0;
         else if (is_data && idx_r != IDX_MAX)
            idx_r <= idx_r + 3'h1;
         if (wr_data)
            tmp_r <= code;
      end
   end

   // Event permits; enable and disable never coincide
   always_ff @(posedge clock) begin
      if (!nrst) begin
         int_ok_r <= RST_INT_PERMIT; // see R26
         mr_ok_r <= RST_MR_PERMIT;
         hj_ok_r <= RST_HJ_PERMIT;
      end else if (ev_en) begin
         int_ok_r <= int_ok_r | code[EV_INT_BIT]; // see R03
         mr_ok_r <= mr_ok_r | code[EV_MR_BIT];
         hj_ok_r <= hj_ok_r | code[EV_HJ_BIT];
      end else if (ev_dis) begin
         int_ok_r <= int_ok_r & ~code[EV_INT_BIT]; // see R04
         mr_ok_r <= mr_ok_r & ~code[EV_MR_BIT];
         hj_ok_r <= hj_ok_r & ~code[EV_HJ_BIT];
      end
   end

   // Activity state exposed so the host side can scale power
   always_ff @(posedge clock) begin
      if (!nrst)
         act_r <= RST_ACT_STATE; // see R26
      else if (as_b || as_d)
         act_r <= as_val; // see R05 see R06 see R07
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         dyn_addr_r <= 7'h00;
         dyn_valid_r <= 1'b0;
      end else if (addr_drop) begin
         dyn_valid_r <= 1'b0; // see R08
      end else if (aasa) begin
         dyn_addr_r <= STATIC_ADDR; // see R15
         dyn_valid_r <= 1'b1;
      end else if (newda) begin
         dyn_addr_r <= code[7:1]; // see R16 see R17
         dyn_valid_r <= 1'b1;
      end
   end

   // Values under the minimum are dropped rather than clamped
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wr_lim_r <= RST_WR_LIMIT;
         rd_lim_r <= RST_RD_LIMIT;
         pay_lim_r <= RST_PAYLOAD_LIMIT;
      end else begin
         if (mwl_set && lim_in >= WR_LIMIT_MIN)
            wr_lim_r <= lim_in; // see R11
         if (mrl_set && lim_in >= RD_LIMIT_MIN)
            rd_lim_r <= lim_in; // see R12
         if (pay_set && BUS_TRAITS[TRAITS_PAYLOAD_BIT])
            pay_lim_r <= code;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ack_r <= 1'b0;
         resp_r <= 8'h00;
         last_r <= 1'b0;
         stb_r <= 1'b0;
         info_r <= '0;
      end else begin
         if (is_addr || is_stop)
            ack_r <= own_wr || own_rd;
         if (own_rd || (st_r == ST_DRD && is_data)) begin
            resp_r <= resp_byte; // see R18
            last_r <= rd_idx >= 3'(resp_len - 3'h1);
         end
         stb_r <= cmd_take;
         if (cmd_take)
            info_r <= '{code: code, direct: code[7], cls: classify(code)}; // see R01 see R24
      end
   end

   assign dyn_addr = dyn_addr_r;
   assign dyn_addr_valid = dyn_valid_r;
   assign act_state = act_r;
   assign interrupt_request_permit = int_ok_r;
   assign mastership_request_permit = mr_ok_r;
   assign hot_join_permit = hj_ok_r;
   assign write_limit = wr_lim_r;
   assign read_limit = rd_lim_r;
   assign payload_limit = pay_lim_r;
   assign addr_ack = ack_r;
   assign resp_data = resp_r;
   assign resp_last = last_r;
   assign daa_join = st_r == ST_DAA; // see R09
   assign fast_mode_busy = st_r == ST_FAST;
   assign cmd_stb = stb_r;
   assign cmd_info = info_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   wire [7:0] sym_data = sym_s2_r.data;

   chk_code_split: assert property (stb_r |-> info_r.direct == info_r.code[7]) // see R01
      else $error("Direct flag disagrees with code bit 7");
   chk_frame_open: assert property ((st_r == ST_CMD && $past(st_r) != ST_CMD) |->
      $past(is_addr) && $past(sym_data) == 8'hFC) // see R02
      else $error("Command frame opened without broadcast write");
   chk_enable_int: assert property (ev_en && code[EV_INT_BIT] |=> int_ok_r) // see R03
      else $error("Enable did not set interrupt permit");
   chk_disable_hj: assert property (ev_dis && code[EV_HJ_BIT] |=> !hj_ok_r) // see R04
      else $error("Disable did not clear hot-join permit");
   chk_state_zero: assert property (bc_now && code == ACTIVITY_STATE_ZERO_CMD_B |=>
      act_r == 2'h0 [*2]) // see R05
      else $error("Activity state zero not selected");
   chk_addr_drop: assert property (addr_drop |=> !dyn_valid_r) // see R08
      else $error("Dynamic address kept after reset command");
   chk_daa_skip: assert property (cmd_take && code == DYN_ADDR_ASSIGN_ENTER_CMD &&
      dyn_valid_r |=> st_r == ST_SKIP) // see R09
      else $error("Addressed device joined assignment");
   chk_fast_hold: assert property (st_r == ST_FAST && !is_fexit |=> st_r == ST_FAST) // see R14
      else $error("Left fast mode without exit pattern");
   chk_newda_load: assert property (newda && !addr_drop |=>
      dyn_addr_r == $past(sym_data) >> 1 && dyn_valid_r) // see R17
      else $error("New dynamic address not taken");
   chk_reserved_quiet: assert property (cmd_take && classify(code) == CL_RESERVED |=>
      st_r == ST_SKIP && $stable(act_r) && $stable(dyn_addr_r)) // see R25
      else $error("Reserved code changed state");
   chk_limit_floor: assert property (wr_lim_r >= WR_LIMIT_MIN && rd_lim_r >= RD_LIMIT_MIN)
      else $error("Length limit below minimum"); // see R11 see R12

   cov_daa_join: cover property (st_r == ST_DAA);
   cov_fast_round: cover property (st_r == ST_FAST ##1 st_r == ST_IDLE);
   cov_own_read: cover property (own_rd ##1 ack_r);
   cov_limit_set: cover property (mwl_set && lim_in >= WR_LIMIT_MIN);
endmodule

// [src/ccd_pkg.sv]
package ccd_pkg;
   // Bus addressing and symbol kinds delivered by the link front end
   localparam logic [6:0] BCAST_ADDR = 7'h7E;
   localparam logic [1:0] K_ADDR = 2'h0;
   localparam logic [1:0] K_DATA = 2'h1;
   localparam logic [1:0] K_STOP = 2'h2;
   localparam logic [1:0] K_FAST_EXIT = 2'h3;

   // Common command codes, broadcast range
   localparam logic [7:0] ENABLE_EVENTS_CMD_B = 8'h00;
   localparam logic [7:0] DISABLE_EVENTS_CMD_B = 8'h01;
   localparam logic [7:0] ACTIVITY_STATE_ZERO_CMD_B = 8'h02;
   localparam logic [7:0] ACTIVITY_STATE_THREE_CMD_B = 8'h05;
   localparam logic [7:0] DYN_ADDR_RESET_CMD_B = 8'h06;
   localparam logic [7:0] DYN_ADDR_ASSIGN_ENTER_CMD = 8'h07;
   localparam logic [7:0] TARGET_LIST_DEFINE_CMD = 8'h08;
   localparam logic [7:0] WRITE_LIMIT_SET_CMD_B = 8'h09;
   localparam logic [7:0] READ_LIMIT_SET_CMD_B = 8'h0A;
   localparam logic [7:0] TEST_MODE_CMD = 8'h0B;
   localparam logic [7:0] RESERVED_B_FIRST = 8'h0C;
   localparam logic [7:0] RESERVED_B_LAST = 8'h1F;
   localparam logic [7:0] FAST_MODE_ZERO_ENTRY_CMD = 8'h20;
   localparam logic [7:0] FAST_MODE_LAST_ENTRY_CMD = 8'h27;
   localparam logic [7:0] TIMING_EXCHANGE_CMD_B = 8'h28;
   localparam logic [7:0] STATIC_AS_DYNAMIC_CMD = 8'h29;
   localparam logic [7:0] RESERVED_B2_FIRST = 8'h2A;
   localparam logic [7:0] RESERVED_B2_LAST = 8'h60;
   localparam logic [7:0] VENDOR_B_FIRST = 8'h61;
   // Direct range
   localparam logic [7:0] ENABLE_EVENTS_CMD_D = 8'h80;
   localparam logic [7:0] DISABLE_EVENTS_CMD_D = 8'h81;
   localparam logic [7:0] ACTIVITY_STATE_ZERO_CMD_D = 8'h82;
   localparam logic [7:0] ACTIVITY_STATE_THREE_CMD_D = 8'h85;
   localparam logic [7:0] DYN_ADDR_RESET_CMD_D = 8'h86;
   localparam logic [7:0] DYN_FROM_STATIC_ASSIGN_CMD = 8'h87;
   localparam logic [7:0] DYN_ADDR_REPLACE_CMD = 8'h88;
   localparam logic [7:0] WRITE_LIMIT_SET_CMD_D = 8'h89;
   localparam logic [7:0] READ_LIMIT_SET_CMD_D = 8'h8A;
   localparam logic [7:0] WRITE_LIMIT_GET_CMD = 8'h8B;
   localparam logic [7:0] READ_LIMIT_GET_CMD = 8'h8C;
   localparam logic [7:0] PROVISIONAL_ID_GET_CMD = 8'h8D;
   localparam logic [7:0] BUS_TRAITS_GET_CMD = 8'h8E;
   localparam logic [7:0] DEVICE_TRAITS_GET_CMD = 8'h8F;
   localparam logic [7:0] OPERATING_STATE_GET_CMD = 8'h90;
   localparam logic [7:0] MASTERSHIP_ACCEPT_GET_CMD = 8'h91;
   localparam logic [7:0] RESERVED_D_SINGLE = 8'h92;
   localparam logic [7:0] BRIDGE_ENDPOINTS_SET_CMD = 8'h93;
   localparam logic [7:0] SPEED_LIMITS_GET_CMD = 8'h94;
   localparam logic [7:0] FAST_MODE_CAPS_GET_CMD = 8'h95;
   localparam logic [7:0] RESERVED_D_FIRST = 8'h96;
   localparam logic [7:0] RESERVED_D_LAST = 8'h97;
   localparam logic [7:0] TIMING_EXCHANGE_SET_CMD = 8'h98;
   localparam logic [7:0] TIMING_EXCHANGE_GET_CMD = 8'h99;
   localparam logic [7:0] RESERVED_D2_FIRST = 8'h9A;
   localparam logic [7:0] RESERVED_D2_LAST = 8'hDF;
   localparam logic [7:0] VENDOR_D_FIRST = 8'hE0;
   localparam logic [7:0] VENDOR_D_LAST = 8'hFE;

   // Event byte and traits byte field positions
   localparam int EV_INT_BIT = 0;
   localparam int EV_MR_BIT = 1;
   localparam int EV_HJ_BIT = 3;
   localparam int TRAITS_SPEED_BIT = 0;
   localparam int TRAITS_PAYLOAD_BIT = 2;

   // Values after reset and limits
   localparam logic [1:0] RST_ACT_STATE = 2'h0;
   localparam logic RST_INT_PERMIT = 1'b1;
   localparam logic RST_MR_PERMIT = 1'b1;
   localparam logic RST_HJ_PERMIT = 1'b1;
   localparam logic [15:0] RST_WR_LIMIT = 16'h0040;
   localparam logic [15:0] RST_RD_LIMIT = 16'h0040;
   localparam logic [7:0] RST_PAYLOAD_LIMIT = 8'h00;
   localparam logic [15:0] WR_LIMIT_MIN = 16'h0008;
   localparam logic [15:0] RD_LIMIT_MIN = 16'h0010;
   localparam logic [2:0] IDX_MAX = 3'h7;

   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [7:0] data;
   } ccd_sym_t;

   typedef enum logic [2:0] {
      CL_REQUIRED, CL_OPTIONAL, CL_UNSUPPORTED, CL_RESERVED, CL_VENDOR
   } ccd_class_t;

   typedef struct packed {
      logic [7:0] code;
      logic direct;
      ccd_class_t cls;
   } ccd_cmd_info_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_BDATA, ST_DWAIT, ST_DWR, ST_DRD, ST_SKIP, ST_DAA, ST_FAST
   } ccd_state_t;
endpackage
